// file: design/fpe_consts.vh
// constants for the flash program/erase controller
// Overview of operation
// R1: flash is programmed one byte per operation, via debug port or software stores.
// R2: a byte write only clears bits; 1 to 0, never 0 to 1.
// R3: erase clears a whole 512-byte page to all 0xFF.
// R4: hardware times every write and erase itself; software never polls.
// R5: processor execution is stalled for the whole write or erase.
// R6: key register must receive 0xA5 then 0xF1, any delay between.
// R7: wrong or out-of-order key disables software flash writes until reset.
// R8: a flash store before full key sequence also disables software writes.
// R9: unlock returns to locked after each operation; keys needed again.
// R10: with store write enable set, data-move stores go to flash.
// R11: store write enable stays set until software clears it.
// R12: erase: set erase and write enable, keys, store into the page.
// R13: program: write enable set, erase enable clear, keys, store one byte.
// R14: software repeats both keys and a store for every byte.
// R15: software should disable interrupts before erase or write sequences.
// R16: software clears store write enable after its flash writes.
// R17: data-move reads always go to data RAM; flash read by code reads.
// R18: on 16 kB parts, 512 bytes at 0x3E00 are reserved, not user flash.
// R19: debug port is the only programming path for a blank device.
// R20: erase needs both store write enable and erase enable at 1.
// R21: with write enable clear, stores go to data RAM, key state untouched.
// R22: key machine: locked, first key, unlocked; sticky disabled on errors.
`ifndef FPE_CONSTS_VH
`define FPE_CONSTS_VH

`define FPE_KEY_FIRST    8'hA5
`define FPE_KEY_SECOND   8'hF1
`define FPE_ERASED       8'hFF
`define FPE_ADDR_W       14
`define FPE_PAGE_BITS    9
`define FPE_FLASH_BYTES  16384
`define FPE_SMALL_TOP    14'h2000
`define FPE_RSV_BASE     14'h3E00
`define FPE_PAGE_LAST    9'h1FF

`define FPE_CLK_NS       5
`define FPE_WRITE_NS     40000
`define FPE_ERASE_NS     10000000
// write and erase time in clock cycles, sized to the counter width
`define FPE_WRITE_CYC    21'd8000
`define FPE_ERASE_CYC    21'd2000000
`define FPE_CNT_W        21

`define FPE_KS_LOCKED    2'h0
`define FPE_KS_FIRST     2'h1
`define FPE_KS_UNLOCKED  2'h2
`define FPE_KS_DISABLED  2'h3

`define FPE_ST_IDLE      2'h0
`define FPE_ST_PROG      2'h1
`define FPE_ST_ERASE     2'h2

`endif

// file: design/fpe_flash_array.v
// byte-wide flash storage with program-AND and forced erase write
`timescale 1ns/1ps
`include "fpe_consts.vh"
module fpe_flash_array (
	// clock
	input  wire                     clk,
	// write port
	input  wire                     we,
	input  wire                     force_wr,
	input  wire [`FPE_ADDR_W-1:0]   waddr,
	input  wire [7:0]               wdata,
	// read port
	input  wire [`FPE_ADDR_W-1:0]   raddr,
	output reg  [7:0]               rdata_ff
);
	reg [7:0] mem [0:`FPE_FLASH_BYTES-1];

	always @(posedge clk) begin
		if (we) begin
			if (force_wr)
				mem[waddr] <= wdata;
			else
				mem[waddr] <= mem[waddr] & wdata; // R2
		end
		rdata_ff <= mem[raddr];
	end
endmodule // fpe_flash_array

// file: design/fpe_key_fsm.v
// lock-and-key state machine guarding software flash operations
`timescale 1ns/1ps
`include "fpe_consts.vh"
module fpe_key_fsm (
	// clock and reset
	input  wire       clk,
	input  wire       resetn,
	// key register writes
	input  wire       key_wr,
	input  wire [7:0] key_data,
	// operation events
	input  wire       attempt,
	input  wire       consume,
	// state
	output wire [1:0] state,
	output wire       unlocked
);
	localparam [1:0] S_LOCKED   = `FPE_KS_LOCKED;
	localparam [1:0] S_FIRST    = `FPE_KS_FIRST;
	localparam [1:0] S_UNLOCKED = `FPE_KS_UNLOCKED;
	localparam [1:0] S_DISABLED = `FPE_KS_DISABLED;

	reg [1:0] state_ff;
	reg [1:0] nxt_state;

	assign state    = state_ff;
	assign unlocked = (state_ff == S_UNLOCKED);

	always @* begin
		nxt_state = state_ff;
		case (state_ff)
		S_LOCKED: begin
			if (attempt)
				nxt_state = S_DISABLED; // R8
			else if (key_wr && key_data == `FPE_KEY_FIRST)
				nxt_state = S_FIRST; // R6
			else if (key_wr)
				nxt_state = S_DISABLED; // R7
		end
		S_FIRST: begin
			if (attempt)
				nxt_state = S_DISABLED; // R8
			else if (key_wr && key_data == `FPE_KEY_SECOND)
				nxt_state = S_UNLOCKED; // R6
			else if (key_wr)
				nxt_state = S_DISABLED; // R7
		end
		S_UNLOCKED: begin
			if (key_wr)
				nxt_state = S_DISABLED; // R7
			else if (consume)
				nxt_state = S_LOCKED; // R9
		end
		S_DISABLED: nxt_state = S_DISABLED; // R22
		default:    nxt_state = S_DISABLED;
		endcase
	end

	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			state_ff <= S_LOCKED;
		else
			state_ff <= nxt_state; // R22
	end
endmodule // fpe_key_fsm

// file: design/fpe_ctrl.v
// flash program/erase controller: store steering, key lock, timing, stall
`timescale 1ns/1ps
`include "fpe_consts.vh"
module fpe_ctrl #(
	parameter [`FPE_CNT_W-1:0] WRITE_CYCLES = `FPE_WRITE_CYC,
	parameter [`FPE_CNT_W-1:0] ERASE_CYCLES = `FPE_ERASE_CYC
) (
	// clock and reset
	input  wire                   CLK,
	input  wire                   RESETN,
	// device variant strap: high for the 16 kB part
	input  wire                   VARIANT_16K,
	// program store control register write
	input  wire                   CTRL_WR,
	input  wire                   CTRL_WRITE_EN,
	input  wire                   CTRL_ERASE_EN,
	// flash key register write
	input  wire                   KEY_WR,
	input  wire [7:0]             KEY_DATA,
	// external data move from the core
	input  wire                   XMOVE_WR,
	input  wire                   XMOVE_RD,
	input  wire [15:0]            XMOVE_ADDR,
	input  wire [7:0]             XMOVE_WDATA,
	// external data ram side
	output reg                    EXTERNAL_DATA_RAM_WE_FF,
	output reg                    EXTERNAL_DATA_RAM_RE_FF,
	output reg  [15:0]            EXTERNAL_DATA_RAM_ADDR_FF,
	output reg  [7:0]             EXTERNAL_DATA_RAM_WDATA_FF,
	// code read move
	input  wire                   CODE_RD,
	input  wire [15:0]            CODE_ADDR,
	output wire [7:0]             CODE_RDATA,
	output reg                    CODE_VALID_FF,
	// two-wire debug port programming
	input  wire                   DBG_WR,
	input  wire                   DBG_ERASE,
	input  wire [15:0]            DBG_ADDR,
	input  wire [7:0]             DBG_WDATA,
	output wire                   DBG_BUSY,
	// status
	output wire                   STALL,
	output wire                   STORE_WRITE_EN,
	output wire                   STORE_ERASE_EN,
	output wire [1:0]             KEY_STATE,
	output wire                   LOCKOUT,
	output reg                    ACCESS_ERR_FF
);
	localparam [1:0] ST_IDLE  = `FPE_ST_IDLE;
	localparam [1:0] ST_PROG  = `FPE_ST_PROG;
	localparam [1:0] ST_ERASE = `FPE_ST_ERASE;
	localparam       AW       = `FPE_ADDR_W;
	localparam       PB       = `FPE_PAGE_BITS;

	// address outside user flash for this variant
	function addr_blocked;
		input [15:0] a;
		input        big;
		begin
			if (big)
				addr_blocked = (a[15:AW] != 2'h0) ||
					(a[AW-1:0] >= `FPE_RSV_BASE); // R18
			else
				addr_blocked = (a[15:AW] != 2'h0) ||
					(a[AW-1:0] >= `FPE_SMALL_TOP);
		end
	endfunction

	reg                 we_ff;
	reg                 ee_ff;
	reg [1:0]           state_ff;
	reg [1:0]           nxt_state;
	reg [`FPE_CNT_W-1:0] cnt_ff;
	reg [`FPE_CNT_W-1:0] nxt_cnt;
	reg [PB-1:0]        walk_ff;
	reg [PB-1:0]        nxt_walk;
	reg                 walk_done_ff;
	reg                 nxt_walk_done;
	reg [AW-1:0]        op_addr_ff;
	reg [AW-1:0]        nxt_op_addr;
	reg [7:0]           op_data_ff;
	reg [7:0]           nxt_op_data;

	wire       sw_store;
	wire       unlocked;
	wire [1:0] key_state;
	wire       sw_ok;
	wire       sw_go;
	wire       sw_erase;
	wire       dbg_go;
	wire       attempt;
	wire       consume;
	wire       timer_done;
	wire       arr_we;
	wire       arr_force;
	wire [AW-1:0] arr_waddr;
	wire [7:0]    arr_wdata;

	// program store control bits hold until software rewrites them
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			we_ff <= 1'b0;
			ee_ff <= 1'b0;
		end else if (CTRL_WR) begin
			we_ff <= CTRL_WRITE_EN; // R11
			ee_ff <= CTRL_ERASE_EN;
		end
	end

	assign STORE_WRITE_EN = we_ff;
	assign STORE_ERASE_EN = ee_ff;

	// stores reach the controller only while write enable is set
	assign sw_store = XMOVE_WR && we_ff && (state_ff == ST_IDLE); // R10 R21
	assign sw_ok    = unlocked && !addr_blocked(XMOVE_ADDR, VARIANT_16K);
	assign sw_go    = sw_store && sw_ok;
	assign sw_erase = ee_ff; // R20 R12
	assign attempt  = sw_store && !unlocked; // R8
	assign consume  = sw_store && unlocked; // R9
	assign dbg_go   = !sw_store && (state_ff == ST_IDLE) &&
		(DBG_WR || DBG_ERASE) &&
		!addr_blocked(DBG_ADDR, VARIANT_16K); // R1 R19

	fpe_key_fsm u_key (
		.clk      (CLK),
		.resetn   (RESETN),
		.key_wr   (KEY_WR),
		.key_data (KEY_DATA),
		.attempt  (attempt),
		.consume  (consume),
		.state    (key_state),
		.unlocked (unlocked)
	);

	assign KEY_STATE = key_state;
	assign LOCKOUT   = (key_state == `FPE_KS_DISABLED); // R7

	// operation sequencer
	assign timer_done = (state_ff == ST_PROG) ?
		(cnt_ff >= WRITE_CYCLES - 1'b1) :
		(cnt_ff >= ERASE_CYCLES - 1'b1) && walk_done_ff;

	always @* begin
		nxt_state     = state_ff;
		nxt_cnt       = cnt_ff;
		nxt_walk      = walk_ff;
		nxt_walk_done = walk_done_ff;
		nxt_op_addr   = op_addr_ff;
		nxt_op_data   = op_data_ff;
		case (state_ff)
		ST_IDLE: begin
			nxt_cnt       = {`FPE_CNT_W{1'b0}};
			nxt_walk      = {PB{1'b0}};
			nxt_walk_done = 1'b0;
			if (sw_go) begin
				nxt_op_addr = XMOVE_ADDR[AW-1:0];
				nxt_op_data = XMOVE_WDATA;
				nxt_state   = sw_erase ? ST_ERASE : ST_PROG; // R12 R13
			end else if (dbg_go) begin
				nxt_op_addr = DBG_ADDR[AW-1:0];
				nxt_op_data = DBG_WDATA;
				nxt_state   = DBG_ERASE ? ST_ERASE : ST_PROG;
			end
		end
		ST_PROG: begin
			nxt_cnt = cnt_ff + 1'b1; // R4
			if (timer_done)
				nxt_state = ST_IDLE;
		end
		ST_ERASE: begin
			if (cnt_ff < ERASE_CYCLES - 1'b1)
				nxt_cnt = cnt_ff + 1'b1; // R4
			if (!walk_done_ff) begin
				nxt_walk = walk_ff + 1'b1;
				if (walk_ff == `FPE_PAGE_LAST)
					nxt_walk_done = 1'b1;
			end
			if (timer_done)
				nxt_state = ST_IDLE;
		end
		default: nxt_state = ST_IDLE;
		endcase
	end

	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff     <= ST_IDLE;
			cnt_ff       <= {`FPE_CNT_W{1'b0}};
			walk_ff      <= {PB{1'b0}};
			walk_done_ff <= 1'b0;
			op_addr_ff   <= {AW{1'b0}};
			op_data_ff   <= 8'h00;
		end else begin
			state_ff     <= nxt_state;
			cnt_ff       <= nxt_cnt;
			walk_ff      <= nxt_walk;
			walk_done_ff <= nxt_walk_done;
			op_addr_ff   <= nxt_op_addr;
			op_data_ff   <= nxt_op_data;
		end
	end

	// core waits while the array is busy
	assign STALL    = (state_ff != ST_IDLE); // R5
	assign DBG_BUSY = (state_ff != ST_IDLE);

	// program writes once; erase walks every byte of the page
	assign arr_we    = ((state_ff == ST_PROG) && (cnt_ff == 0)) ||
		((state_ff == ST_ERASE) && !walk_done_ff);
	assign arr_force = (state_ff == ST_ERASE);
	assign arr_waddr = (state_ff == ST_ERASE) ?
		{op_addr_ff[AW-1:PB], walk_ff} : op_addr_ff; // R3
	assign arr_wdata = (state_ff == ST_ERASE) ? `FPE_ERASED : op_data_ff; // R3 R2

	fpe_flash_array u_array (
		.clk      (CLK),
		.we       (arr_we),
		.force_wr (arr_force),
		.waddr    (arr_waddr),
		.wdata    (arr_wdata),
		.raddr    (CODE_ADDR[AW-1:0]),
		.rdata_ff (CODE_RDATA)
	);

	// data ram path and code read answer
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			EXTERNAL_DATA_RAM_WE_FF    <= 1'b0;
			EXTERNAL_DATA_RAM_RE_FF    <= 1'b0;
			EXTERNAL_DATA_RAM_ADDR_FF  <= 16'h0000;
			EXTERNAL_DATA_RAM_WDATA_FF <= 8'h00;
			CODE_VALID_FF <= 1'b0;
			ACCESS_ERR_FF <= 1'b0;
		end else begin
			EXTERNAL_DATA_RAM_WE_FF    <= XMOVE_WR && !we_ff; // R21
			EXTERNAL_DATA_RAM_RE_FF    <= XMOVE_RD; // R17
			EXTERNAL_DATA_RAM_ADDR_FF  <= XMOVE_ADDR;
			EXTERNAL_DATA_RAM_WDATA_FF <= XMOVE_WDATA;
			CODE_VALID_FF <= CODE_RD && (state_ff == ST_IDLE); // R17
			ACCESS_ERR_FF <= sw_store && !sw_ok;
		end
	end
endmodule // fpe_ctrl

// file: verification/fpe_ctrl_chk.sv
// concurrent checks on the flash program/erase controller ports
`timescale 1ns/1ps
module fpe_ctrl_chk #(
	parameter [20:0] WRITE_CYCLES = 21'h14,
	parameter [20:0] ERASE_CYCLES = 21'h28
) (
	// clock and reset
	input wire        CLK,
	input wire        RESETN,
	// requests
	input wire        VARIANT_16K,
	input wire        CTRL_WR,
	input wire        CTRL_WRITE_EN,
	input wire        KEY_WR,
	input wire [7:0]  KEY_DATA,
	input wire        XMOVE_WR,
	input wire        XMOVE_RD,
	input wire [15:0] XMOVE_ADDR,
	input wire        DBG_ERASE,
	// answers
	input wire        EXTERNAL_DATA_RAM_WE_FF,
	input wire        EXTERNAL_DATA_RAM_RE_FF,
	input wire        STALL,
	input wire        STORE_WRITE_EN,
	input wire        STORE_ERASE_EN,
	input wire [1:0]  KEY_STATE,
	input wire        LOCKOUT,
	input wire        ACCESS_ERR_FF
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESETN);
	reg  [20:0] len_ff;
	reg         ers_ff;
	wire        sw_op = XMOVE_WR && STORE_WRITE_EN && !STALL;
	wire        a_ok  = XMOVE_ADDR < (VARIANT_16K ? 16'h3E00 : 16'h2000);
	wire        k0    = KEY_STATE == 2'h0 && KEY_DATA == 8'hA5;
	wire        k1    = KEY_STATE == 2'h1 && KEY_DATA == 8'hF1;
	// an erase never lasts less than one page walk
	wire [20:0] e_len = ERASE_CYCLES > 21'h201 ? ERASE_CYCLES : 21'h201;
	always @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			len_ff <= 21'h0;
			ers_ff <= 1'b0;
		end else begin
			len_ff <= STALL ? len_ff + 21'h1 : 21'h0;
			if (!STALL)
				ers_ff <= sw_op ? STORE_ERASE_EN : DBG_ERASE;
		end
	end
	op_length_a: assert property ($fell(STALL) |->
		len_ff == (ers_ff ? e_len : WRITE_CYCLES)) else $error("op length");
	op_start_a: assert property (sw_op && KEY_STATE == 2'h2 && a_ok
		|=> STALL && KEY_STATE == 2'h0) else $error("op start");
	addr_block_a: assert property (sw_op && KEY_STATE == 2'h2 && !a_ok
		|=> ACCESS_ERR_FF && !STALL && !LOCKOUT) else $error("blocked addr");
	early_op_a: assert property (sw_op && KEY_STATE != 2'h2
		|=> LOCKOUT && !STALL) else $error("early store");
	key_step_a: assert property (KEY_WR && !STALL && (k0 || k1)
		|=> KEY_STATE == $past(KEY_STATE) + 2'h1) else $error("key step");
	key_bad_a: assert property (KEY_WR && !STALL && !k0 && !k1
		|=> LOCKOUT) else $error("bad key");
	lock_sticky_a: assert property (LOCKOUT |=> LOCKOUT)
		else $error("lockout lost");
	ram_store_a: assert property (XMOVE_WR && !STORE_WRITE_EN && !KEY_WR
		|=> EXTERNAL_DATA_RAM_WE_FF && $stable(KEY_STATE)) else $error("ram store");
	flash_store_a: assert property (sw_op |=> !EXTERNAL_DATA_RAM_WE_FF)
		else $error("flash store hit ram");
	ram_read_a: assert property (XMOVE_RD |=> EXTERNAL_DATA_RAM_RE_FF)
		else $error("ram read");
	wen_hold_a: assert property (!CTRL_WR |=> $stable(STORE_WRITE_EN))
		else $error("write enable moved");
	wen_load_a: assert property (CTRL_WR
		|=> STORE_WRITE_EN == $past(CTRL_WRITE_EN)) else $error("wen load");
	cover property ($fell(STALL) && ers_ff);
	cover property ($rose(LOCKOUT));
	cover property (ACCESS_ERR_FF);
endmodule // fpe_ctrl_chk
bind fpe_ctrl fpe_ctrl_chk #(.WRITE_CYCLES(WRITE_CYCLES),
	.ERASE_CYCLES(ERASE_CYCLES)) u_chk (.*);

// file: verification/fpe_core_mdl.sv
// processor core model issuing control, key, store and code reads
`timescale 1ns/1ps
module fpe_core_mdl (
	// clock and core stall
	input wire        CLK,
	input wire        stall,
	input wire [7:0]  rdata,
	// core requests
	output reg        ctrl_wr,
	output reg        we,
	output reg        ee,
	output reg        key_wr,
	output reg [7:0]  key_d,
	output reg        xwr,
	output reg        xrd,
	output reg [15:0] xa,
	output reg [7:0]  xd,
	output reg        crd,
	output reg [15:0] ca
);
	initial {ctrl_wr, we, ee, key_wr, key_d, xwr, xrd, xa, xd, crd, ca} = 0;
	task cyc; @(posedge CLK); #1; endtask
	task ctrl(input w, input e);
		cyc;
		ctrl_wr = 1'b1;
		we = w;
		ee = e;
		cyc;
		ctrl_wr = 1'b0;
	endtask
	task key(input [7:0] k);
		cyc;
		key_wr = 1'b1;
		key_d = k;
		cyc;
		key_wr = 1'b0;
	endtask
	// returns just after the store edge, pulses still visible
	task store(input [15:0] a, input [7:0] d);
		cyc;
		xwr = 1'b1;
		xa = a;
		xd = d;
		cyc;
		xwr = 1'b0;
	endtask
	task xread(input [15:0] a);
		cyc;
		xrd = 1'b1;
		xa = a;
		cyc;
		xrd = 1'b0;
	endtask
	task cread(input [15:0] a, output [7:0] q);
		cyc;
		crd = 1'b1;
		ca = a;
		cyc;
		q = rdata;
		crd = 0;
	endtask
	// the core executes nothing while stalled
	task idle; while (stall) cyc; endtask
	// no interrupts are modelled, so nothing breaks into a sequence
	task op(input e, input [15:0] a, input [7:0] d);
		ctrl(1'b1, e);
		key(8'hA5);
		key(8'hF1);
		store(a, d);
		idle;
	endtask
endmodule // fpe_core_mdl

// file: verification/test_flash_program_erase_ctrl.sv
// self-checking bench for the flash program/erase controller
`timescale 1ns/1ps
module test_flash_program_erase_ctrl;
	reg         CLK, RESETN;
	reg         VARIANT_16K = 1'b1, DBG_WR = 1'b0, DBG_ERASE = 1'b0;
	reg  [15:0] DBG_ADDR = 16'h0;
	reg  [7:0]  DBG_WDATA = 8'h0;
	wire        CTRL_WR, CTRL_WRITE_EN, CTRL_ERASE_EN, KEY_WR, XMOVE_WR;
	wire        XMOVE_RD, CODE_RD, EXTERNAL_DATA_RAM_WE_FF, EXTERNAL_DATA_RAM_RE_FF, CODE_VALID_FF;
	wire        DBG_BUSY, STALL, STORE_WRITE_EN, STORE_ERASE_EN;
	wire        LOCKOUT, ACCESS_ERR_FF;
	wire [15:0] XMOVE_ADDR, CODE_ADDR, EXTERNAL_DATA_RAM_ADDR_FF;
	wire [7:0]  EXTERNAL_DATA_RAM_WDATA_FF;
	wire [7:0]  KEY_DATA, XMOVE_WDATA, CODE_RDATA;
	wire [1:0]  KEY_STATE;
	integer     error_cnt = 0, checked = 0, cyc_n = 0, i;
	reg  [15:0] pa;
	reg  [7:0]  d1, d2, q;
	reg  [47:0] bad;
	fpe_ctrl #(.WRITE_CYCLES(21'h14), .ERASE_CYCLES(21'h28)) DUT (.*);
	fpe_core_mdl core (.CLK(CLK), .stall(STALL), .rdata(CODE_RDATA),
		.ctrl_wr(CTRL_WR), .we(CTRL_WRITE_EN), .ee(CTRL_ERASE_EN),
		.key_wr(KEY_WR), .key_d(KEY_DATA), .xwr(XMOVE_WR), .xrd(XMOVE_RD),
		.xa(XMOVE_ADDR), .xd(XMOVE_WDATA), .crd(CODE_RD), .ca(CODE_ADDR));
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	function [7:0] prog_val(input [7:0] o, input [7:0] d);
		prog_val = o & d;
	endfunction
	task chk(input string n, input [15:0] e, input [15:0] g);
		checked++;
		if (g !== e) begin
			error_cnt++;
			$display("Error %0s expected %h seen %h", n, e, g);
		end
	endtask
	task complete_run;
		if (error_cnt == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	task rst;
		RESETN = 1'b0;
		repeat (3) @(posedge CLK);
		#1;
		RESETN = 1'b1;
	endtask
	always @(posedge CLK) begin
		cyc_n++;
		if (cyc_n == 8000) begin
			error_cnt++;
			complete_run;
		end
	end
	initial begin
		rst;
		d1 = $urandom(9);
		chk("kstate", 8'h0, KEY_STATE);
		chk("wen", 8'h0, STORE_WRITE_EN);
		d1 = $urandom;
		d2 = $urandom;
		pa = {3'h0, d1[3:0], 9'h0};
		core.op(1'b1, pa + 16'h77, 8'h00);
		core.cread(pa, q);
		chk("erase lo", 8'hFF, q);
		core.cread(pa + 16'h1FF, q);
		chk("erase hi", 8'hFF, q);
		core.op(1'b0, pa + 16'h5, d1);
		core.op(1'b0, pa + 16'h5, d2);
		core.cread(pa + 16'h5, q);
		chk("prog", prog_val(d1, d2), q);
		chk("relock", 8'h0, KEY_STATE);
		core.key(8'hA5);
		core.ctrl(1'b0, 1'b0);
		chk("een", 8'h0, STORE_ERASE_EN);
		core.store(pa, d1);
		chk("ram we", 8'h1, EXTERNAL_DATA_RAM_WE_FF);
		chk("ram addr", pa, EXTERNAL_DATA_RAM_ADDR_FF);
		chk("ram data", d1, EXTERNAL_DATA_RAM_WDATA_FF);
		chk("key kept", 8'h1, KEY_STATE);
		core.xread(pa);
		chk("ram re", 8'h1, EXTERNAL_DATA_RAM_RE_FF);
		core.key(8'hF1);
		core.ctrl(1'b1, 1'b0);
		core.store(16'h3E00 + d2, d1);
		chk("blocked", 8'h1, ACCESS_ERR_FF);
		chk("no stall", 8'h0, STALL);
		@(posedge CLK);
		#1;
		DBG_WR = 1'b1;
		DBG_ADDR = pa + 16'h9;
		DBG_WDATA = d2;
		@(posedge CLK);
		#1;
		DBG_WR = 1'b0;
		chk("dbg busy", 8'h1, DBG_BUSY);
		core.idle;
		core.cread(pa + 16'h9, q);
		chk("dbg prog", d2, q);
		core.store(pa + 16'h9, 8'h00);
		chk("early", 8'h1, LOCKOUT);
		core.op(1'b0, pa + 16'h9, 8'h00);
		core.cread(pa + 16'h9, q);
		chk("locked", d2, q);
		@(posedge CLK);
		#1;
		DBG_ERASE = 1'b1;
		DBG_ADDR = pa + 16'h30;
		@(posedge CLK);
		#1;
		DBG_ERASE = 1'b0;
		core.idle;
		core.cread(pa + 16'h9, q);
		chk("dbg erase", 8'hFF, q);
		chk("code valid", 8'h1, CODE_VALID_FF);
		bad = {16'hF1A5, 16'hA5A5, 8'hA5, 8'hF1 ^ (d1 | 8'h01)};
		for (i = 0; i < 3; i++) begin
			rst;
			chk("unlock", 8'h0, LOCKOUT);
			core.key(bad[i*16+8 +: 8]);
			core.key(bad[i*16 +: 8]);
			chk("bad key", 8'h1, LOCKOUT);
		end
		rst;
		VARIANT_16K = 1'b0;
		core.op(1'b0, 16'h2000 + d2, d1);
		chk("blocked 8k", 8'h1, ACCESS_ERR_FF);
		complete_run;
	end
endmodule // test_flash_program_erase_ctrl
